// *** core/ssf_supervisor.sv ***
`timescale 1ns/1ps
`include "ssf_defs.svh"

module ssf_supervisor
  import ssf_pkg::*;
#(
  parameter int FLASH_HALF_CYC = `SSF_FLASH_MS * `SSF_CLK_KHZ
)
(
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  // register port
  input  wire logic [`SSF_AW-1:0] reg_addr,
  input  wire logic [`SSF_DW-1:0] reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [`SSF_DW-1:0] reg_rdata,
  // pins
  input  wire logic               enable_pin,
  input  wire ssf_fault_t         fault_pin,
  // same-clock sources
  input  wire logic               param_data_bad,
  input  wire ssf_proc_t          proc_in,
  // power stage and spool loop
  output ssf_loop_t               loop_ctrl,
  output logic signed [15:0]      spool_setpoint,
  output logic        [4:0]       current_loop_p_gain,
  output logic        [6:0]       current_loop_i_gain,
  output logic        [4:0]       pwm_step,
  output logic        [11:0]      pwm_hz,
  // status
  output logic                    ready_out,
  output logic                    ready_led
);

  localparam logic [239:0] PWM_TAB = `SSF_PWM_HZ_TAB;

  typedef struct packed {
    logic               gain_auto_adjust;
    ssf_mon_t           fault_monitor_select;
    logic               internal_spool_loop;
    logic               ext_press_req;
    logic [4:0]         pwm_step;
    logic [11:0]        pwm_hz;
    logic [4:0]         p_user;
    logic [6:0]         i_user;
    logic [4:0]         p_gain;
    logic [6:0]         i_gain;
    ssf_spool_t         spool_loop_mode;
    logic signed [15:0] fallback_output;
    logic [3:0]         hist_idx;
    logic [15:0]        rdata;
    ssf_fault_t         flt_s1;
    ssf_fault_t         flt_s2;
    logic               en_s1;
    logic               en_s2;
    logic               boot_done;
    logic               data_err;
    ssf_fault_t         fault_act;
    logic               ready;
    logic               log_en;
    logic [3:0]         log_cause;
    logic [23:0]        flash_cnt;
    logic               flash;
    logic               ready_led;
    ssf_loop_t          loop;
    logic signed [15:0] setpoint;
  } ssf_state_t;

  ssf_state_t st_reg;
  ssf_state_t st_next;
  logic [3:0] hist_rd;

  ssf_history u_history (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .log_en    (st_reg.log_en),
    .log_cause (st_reg.log_cause),
    .rd_idx    (st_reg.hist_idx),
    .rd_cause  (hist_rd)
  );

  // lowest set fault bit names the cause, codes start at 1
  function automatic logic [3:0] cause_of(input ssf_fault_t f,
                                          input logic       derr,
                                          input logic       sim);
    logic [3:0] c;
    c = `SSF_CAUSE_OTH;
    for (int i = 7; i >= 0; i--)
      if (f[i])
        c = 4'(i + 1);
    if (derr)
      c = `SSF_CAUSE_DATA;
    if (sim)
      c = `SSF_CAUSE_SIM;
    return c;
  endfunction

  always_comb
  begin
    logic       sim;
    logic       mon_on;
    logic       stage_kill;
    logic       fault_any;
    logic       ready_new;
    logic [4:0] wstep;
    ssf_fault_t fmask;
    st_next = st_reg;
    sim = 1'b0;
    mon_on = 1'b0;
    stage_kill = 1'b0;
    fault_any = 1'b0;
    ready_new = 1'b0;
    wstep = reg_wdata[4:0];
    fmask = '0;

    // pins pass two flip-flops before any use
    st_next.flt_s1 = fault_pin;
    st_next.flt_s2 = st_reg.flt_s1;
    st_next.en_s1 = enable_pin;
    st_next.en_s2 = st_reg.en_s1;

    // register writes
    st_next.rdata = '0;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `SSF_OFS_CTRL:
        begin
          st_next.gain_auto_adjust = reg_wdata[`SSF_CTRL_AUTO];
          if (reg_wdata[`SSF_CTRL_MON] != 2'b11)
            st_next.fault_monitor_select =
              ssf_mon_t'(reg_wdata[`SSF_CTRL_MON]);
          st_next.internal_spool_loop = reg_wdata[`SSF_CTRL_INTL];
          st_next.ext_press_req = reg_wdata[`SSF_CTRL_EXTP];
        end
        `SSF_OFS_PWM_STEP:
          if (reg_wdata[15:5] == '0 && wstep <= `SSF_PWM_STEPS)
            st_next.pwm_step = wstep;
        `SSF_OFS_P_GAIN:
          if (!st_reg.gain_auto_adjust && reg_wdata[15:5] == '0
              && wstep <= `SSF_P_MAX)
            st_next.p_user = wstep;
        `SSF_OFS_I_GAIN:
          if (!st_reg.gain_auto_adjust && reg_wdata[15:7] == '0
              && reg_wdata[6:0] >= `SSF_I_MIN
              && reg_wdata[6:0] <= `SSF_I_MAX)
            st_next.i_user = reg_wdata[6:0];
        `SSF_OFS_SPOOL:
          unique case (reg_wdata[1:0])
            2'b00:   st_next.spool_loop_mode = SPM_NORMAL;
            2'b01:   st_next.spool_loop_mode = SPM_SIM_OL;
            2'b10:   st_next.spool_loop_mode = SPM_SIM_CL;
            default: st_next.spool_loop_mode = st_reg.spool_loop_mode;
          endcase
        `SSF_OFS_FALLBACK:
          if ($signed(reg_wdata) >= `SSF_FB_MIN
              && $signed(reg_wdata) <= `SSF_FB_MAX)
            st_next.fallback_output = $signed(reg_wdata);
        `SSF_OFS_HIST_IDX:
          st_next.hist_idx = reg_wdata[3:0];
        `SSF_OFS_SAVE:
          st_next.data_err = 1'b0;
        default:
          st_next.rdata = '0;
      endcase
    end

    // boot check taken once after release; placed after the save decode
    // so a save in that same cycle cannot hide a bad image
    st_next.boot_done = 1'b1;
    if (!st_reg.boot_done)
      st_next.data_err = param_data_bad;

    // register reads, data valid in the next cycle only
    if (reg_rd)
    begin
      unique case (reg_addr)
        `SSF_OFS_CTRL:
          st_next.rdata = {11'h000, st_reg.ext_press_req,
                           st_reg.internal_spool_loop,
                           st_reg.fault_monitor_select,
                           st_reg.gain_auto_adjust};
        `SSF_OFS_PWM_STEP: st_next.rdata = {11'h000, st_reg.pwm_step};
        `SSF_OFS_P_GAIN:   st_next.rdata = {11'h000, st_reg.p_gain};
        `SSF_OFS_I_GAIN:   st_next.rdata = {9'h000, st_reg.i_gain};
        `SSF_OFS_SPOOL:    st_next.rdata = {14'h0000, st_reg.spool_loop_mode};
        `SSF_OFS_FALLBACK: st_next.rdata = st_reg.fallback_output;
        `SSF_OFS_STATUS:
          st_next.rdata = {5'h00, st_reg.en_s2, st_reg.data_err,
                           st_reg.ready, st_reg.fault_act};
        `SSF_OFS_HIST_IDX: st_next.rdata = {12'h000, st_reg.hist_idx};
        `SSF_OFS_HIST:     st_next.rdata = {12'h000, hist_rd};
        `SSF_OFS_PWM_HZ:   st_next.rdata = {4'h0, st_reg.pwm_hz};
        // live process values
        `SSF_OFS_PV_DEM:
          st_next.rdata = proc_in.swivel_demand_preramp;
        `SSF_OFS_PV_CTRL:  st_next.rdata = proc_in.swivel_ctrl_out;
        `SSF_OFS_PV_POS:   st_next.rdata = proc_in.spool_pos;
        `SSF_OFS_PV_IA:    st_next.rdata = proc_in.current_a;
        `SSF_OFS_PV_IB:    st_next.rdata = proc_in.current_b;
        `SSF_OFS_PV_OUT:   st_next.rdata = st_reg.setpoint;
        default:           st_next.rdata = '0;
      endcase
    end

    // pwm frequency and gains
    st_next.pwm_hz = PWM_TAB[12*st_reg.pwm_step +: 12];
    if (st_reg.gain_auto_adjust)
    begin
      if (st_reg.pwm_hz < `SSF_HZ_LOW)
      begin
        st_next.p_gain = `SSF_P_LOWF;
        st_next.i_gain = `SSF_I_LOWF;
      end
      else if (st_reg.pwm_hz > `SSF_HZ_HIGH)
      begin
        st_next.p_gain = `SSF_P_HIGHF;
        st_next.i_gain = `SSF_I_HIGHF;
      end
      else
      begin
        st_next.p_gain = `SSF_P_MIDF;
        st_next.i_gain = `SSF_I_MIDF;
      end
    end
    else
    begin
      st_next.p_gain = st_reg.p_user;
      st_next.i_gain = st_reg.i_user;
    end

    // fault evaluation
    sim = (st_reg.spool_loop_mode != SPM_NORMAL);
    mon_on = (st_reg.fault_monitor_select != MON_OFF);
    if (mon_on)
    begin
      fmask.ain6 = 1'b1;
      fmask.ain10 = 1'b1;
      fmask.ain13 = 1'b1;
      fmask.ain14 = 1'b1;
      fmask.lvdt_loss = 1'b1;
      fmask.ain31 = st_reg.ext_press_req;
    end
    fmask.sol_a = 1'b1;
    fmask.sol_b = 1'b1;
    if (sim)
      fmask = '0;
    st_next.fault_act = st_reg.flt_s2 & fmask;
    fault_any = (st_reg.fault_act != '0) || (st_reg.data_err && !sim);
    stage_kill = st_reg.fault_act.sol_a || st_reg.fault_act.sol_b
              || (st_reg.data_err && !sim);
    ready_new = st_reg.en_s2 && !fault_any && !sim;
    st_next.ready = ready_new;

    // shutdown = ready falling while enable stays applied
    st_next.log_en = st_reg.ready && !ready_new && st_reg.en_s2;
    st_next.log_cause = cause_of(st_reg.fault_act, st_reg.data_err,
                                 sim);

    // ready indicator blinks on a fault under enable
    if (st_reg.flash_cnt >= 24'(FLASH_HALF_CYC - 1))
    begin
      st_next.flash_cnt = '0;
      st_next.flash = !st_reg.flash;
    end
    else
      st_next.flash_cnt = st_reg.flash_cnt + 24'd1;
    st_next.ready_led = st_reg.ready
                     || (st_reg.en_s2 && fault_any && st_reg.flash);

    // output selection
    st_next.loop = '0;
    st_next.setpoint = '0;
    unique case (st_reg.spool_loop_mode)
      SPM_SIM_OL:
      begin
        st_next.loop.stage_on = 1'b1;
        st_next.loop.pilot_only = 1'b1;
        st_next.setpoint = proc_in.swivel_demand_preramp;
      end
      SPM_SIM_CL:
      begin
        st_next.loop.stage_on = 1'b1;
        st_next.loop.pos_loop_run = 1'b1;
        st_next.loop.feedforward_on = 1'b1;
        st_next.setpoint = proc_in.swivel_demand_preramp;
      end
      SPM_NORMAL:
        if (st_reg.ready)
        begin
          st_next.loop.stage_on = 1'b1;
          st_next.loop.pos_loop_run = st_reg.internal_spool_loop;
          st_next.loop.feedforward_on = st_reg.internal_spool_loop;
          st_next.setpoint = proc_in.swivel_ctrl_out;
        end
        else if (st_reg.fallback_output != '0 && !stage_kill)
        begin
          st_next.loop.stage_on = 1'b1;
          st_next.loop.pos_loop_run = st_reg.internal_spool_loop;
          st_next.setpoint = st_reg.fallback_output;
        end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
      st_reg.fault_monitor_select <= MON_ON;
      st_reg.pwm_step <= `SSF_STEP_RST;
      st_reg.p_user <= `SSF_P_RST;
      st_reg.i_user <= `SSF_I_RST;
      st_reg.p_gain <= `SSF_P_RST;
      st_reg.i_gain <= `SSF_I_RST;
      st_reg.spool_loop_mode <= SPM_NORMAL;
    end
    else
      st_reg <= st_next;
  end

  assign reg_rdata = st_reg.rdata;
  assign loop_ctrl = st_reg.loop;
  assign spool_setpoint = st_reg.setpoint;
  assign current_loop_p_gain = st_reg.p_gain;
  assign current_loop_i_gain = st_reg.i_gain;
  assign pwm_step = st_reg.pwm_step;
  assign pwm_hz = st_reg.pwm_hz;
  assign ready_out = st_reg.ready;
  assign ready_led = st_reg.ready_led;

endmodule

// *** core/ssf_defs.svh ***
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

`define SSF_AW 8
`define SSF_DW 16
// register offsets
`define SSF_OFS_CTRL     8'h00
`define SSF_OFS_PWM_STEP 8'h04
`define SSF_OFS_P_GAIN   8'h08
`define SSF_OFS_I_GAIN   8'h0C
`define SSF_OFS_SPOOL    8'h10
`define SSF_OFS_FALLBACK 8'h14
`define SSF_OFS_STATUS   8'h18
`define SSF_OFS_HIST_IDX 8'h1C
`define SSF_OFS_HIST     8'h20
`define SSF_OFS_SAVE     8'h24
`define SSF_OFS_PWM_HZ   8'h28
`define SSF_OFS_PV_DEM   8'h2C
`define SSF_OFS_PV_CTRL  8'h30
`define SSF_OFS_PV_POS   8'h34
`define SSF_OFS_PV_IA    8'h38
`define SSF_OFS_PV_IB    8'h3C
`define SSF_OFS_PV_OUT   8'h40
// ctrl fields
`define SSF_CTRL_AUTO  0
`define SSF_CTRL_MON   2:1
`define SSF_CTRL_INTL  3
`define SSF_CTRL_EXTP  4
// ranges and reset values
`define SSF_PWM_STEPS  5'h13
`define SSF_P_MAX      5'h1E
`define SSF_I_MIN      7'h01
`define SSF_I_MAX      7'h64
`define SSF_P_RST      5'h07
`define SSF_I_RST      7'h28
`define SSF_STEP_RST   5'h0C
`define SSF_FB_MIN     (-16'sd10000)
`define SSF_FB_MAX     16'sd10000
// pwm step frequencies in hz, step 0 in the low bits
`define SSF_PWM_HZ_TAB {12'd2604, 12'd2232, 12'd1953, 12'd1736, \
  12'd1562, 12'd1420, 12'd1201, 12'd976, 12'd781, 12'd624, 12'd488, \
  12'd372, 12'd269, 12'd200, 12'd150, 12'd120, 12'd100, 12'd85, \
  12'd72, 12'd61}
`define SSF_HZ_LOW     12'd250
`define SSF_HZ_HIGH    12'd1000
`define SSF_P_LOWF     5'h02
`define SSF_I_LOWF     7'h3C
`define SSF_P_MIDF     5'h04
`define SSF_I_MIDF     7'h32
`define SSF_P_HIGHF    5'h07
`define SSF_I_HIGHF    7'h28
// history
`define SSF_HIST_N     10
`define SSF_CAUSE_NONE 4'h0
`define SSF_CAUSE_DATA 4'h9
`define SSF_CAUSE_SIM  4'hA
`define SSF_CAUSE_OTH  4'hF
// ready flash
`define SSF_CLK_KHZ    40000
`define SSF_FLASH_MS   250

`endif

// *** core/ssf_pkg.sv ***
package ssf_pkg;

  typedef enum logic [1:0] {SPM_NORMAL, SPM_SIM_OL, SPM_SIM_CL} ssf_spool_t;
  typedef enum logic [1:0] {MON_OFF, MON_ON, MON_AUTO} ssf_mon_t;

  // per-pin fault flags, bit order gives cause codes 1..8
  typedef struct packed {
    logic sol_b;
    logic sol_a;
    logic lvdt_loss;
    logic ain31;
    logic ain14;
    logic ain13;
    logic ain10;
    logic ain6;
  } ssf_fault_t;

  typedef struct packed {
    logic signed [15:0] swivel_demand_preramp;
    logic signed [15:0] swivel_ctrl_out;
    logic signed [15:0] spool_pos;
    logic        [15:0] current_a;
    logic        [15:0] current_b;
  } ssf_proc_t;

  typedef struct packed {
    logic stage_on;
    logic pos_loop_run;
    logic feedforward_on;
    logic pilot_only;
  } ssf_loop_t;

  typedef struct packed {
    logic [9:0][3:0] ent;
  } ssf_hist_t;

endpackage

// *** core/ssf_history.sv ***
`timescale 1ns/1ps
`include "ssf_defs.svh"

// volatile shutdown log: entry 0 oldest, last entry newest
module ssf_history
  import ssf_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // log side
  input  wire logic       log_en,
  input  wire logic [3:0] log_cause,
  // query side
  input  wire logic [3:0] rd_idx,
  output logic      [3:0] rd_cause
);

  ssf_hist_t st_reg;
  ssf_hist_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (log_en)
    begin
      for (int i = 0; i < `SSF_HIST_N - 1; i++)
        st_next.ent[i] = st_reg.ent[i + 1];
      st_next.ent[`SSF_HIST_N - 1] = log_cause;
    end
  end

  // only reset clears it: nothing is kept across power loss
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // unused cells read the blank code
  assign rd_cause = (rd_idx < 4'(`SSF_HIST_N)) ? st_reg.ent[rd_idx]
                                              : `SSF_CAUSE_NONE;

endmodule

// *** tb/ssf_supervisor_monitor.sv ***
`timescale 1ns/1ps
`include "ssf_defs.svh"

module ssf_monitor
  import ssf_pkg::*;
#(
  parameter int FLASH_HALF_CYC = 4
)
(
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               rst_b,
  // register port
  input wire logic [`SSF_AW-1:0] reg_addr,
  input wire logic [`SSF_DW-1:0] reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [`SSF_DW-1:0] reg_rdata,
  // pins and sources
  input wire logic               enable_pin,
  input wire ssf_fault_t         fault_pin,
  input wire logic               param_data_bad,
  input wire ssf_proc_t          proc_in,
  // stage and status
  input wire ssf_loop_t          loop_ctrl,
  input wire logic signed [15:0] spool_setpoint,
  input wire logic [4:0]         current_loop_p_gain,
  input wire logic [6:0]         current_loop_i_gain,
  input wire logic [4:0]         pwm_step,
  input wire logic [11:0]        pwm_hz,
  input wire logic               ready_out,
  input wire logic               ready_led
);
  // shadows of control writes; quiet for 7 cycles means outputs settled
  logic [2:0]         age_reg;
  logic [7:0]         flt_reg;
  logic               auto_reg;
  logic               intl_reg;
  logic [1:0]         mon_reg;
  logic [1:0]         sim_reg;
  logic signed [15:0] fb_reg;
  wire logic settled = age_reg == 3'h7;
  wire logic hi = pwm_hz > `SSF_HZ_HIGH;
  wire logic lo = pwm_hz < `SSF_HZ_LOW;
  wire logic [4:0] p_exp = hi ? `SSF_P_HIGHF : lo ? `SSF_P_LOWF : `SSF_P_MIDF;
  wire logic [6:0] i_exp = hi ? `SSF_I_HIGHF : lo ? `SSF_I_LOWF : `SSF_I_MIDF;
  wire logic fb_ok = $signed(reg_wdata) >= `SSF_FB_MIN
                     && $signed(reg_wdata) <= `SSF_FB_MAX;

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      age_reg  <= 3'h0;
      flt_reg  <= 8'h00;
      auto_reg <= 1'b0;
      intl_reg <= 1'b0;
      mon_reg  <= 2'h1;
      sim_reg  <= 2'h0;
      fb_reg   <= 16'sh0000;
    end
    else
    begin
      flt_reg <= fault_pin;
      age_reg <= (reg_wr || fault_pin != flt_reg) ? 3'h0 :
                 settled ? age_reg : age_reg + 3'h1;
      if (reg_wr && reg_addr == `SSF_OFS_CTRL)
      begin
        auto_reg <= reg_wdata[0];
        intl_reg <= reg_wdata[3];
        if (reg_wdata[2:1] != 2'h3)
          mon_reg <= reg_wdata[2:1];
      end
      if (reg_wr && reg_addr == `SSF_OFS_SPOOL && reg_wdata < 16'h0003)
        sim_reg <= reg_wdata[1:0];
      if (reg_wr && reg_addr == `SSF_OFS_FALLBACK && fb_ok)
        fb_reg <= reg_wdata;
    end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  step_range_a: assert property (pwm_step <= 5'h13)
    else $error("pwm step beyond last entry");
  gain_span_a: assert property (
    current_loop_p_gain <= `SSF_P_MAX && current_loop_i_gain >= `SSF_I_MIN
    && current_loop_i_gain <= `SSF_I_MAX)
    else $error("current loop gain out of span");
  auto_gain_a: assert property (
    settled && auto_reg |-> current_loop_p_gain == p_exp
    && current_loop_i_gain == i_exp)
    else $error("automatic gain does not follow pwm frequency");
  manual_hold_a: assert property (
    settled && !auto_reg |-> $stable(current_loop_p_gain)
    && $stable(current_loop_i_gain))
    else $error("manual gain moved without a write");
  sim_ready_a: assert property (
    settled && sim_reg != 2'h0 |-> !ready_out)
    else $error("ready high in simulation mode");
  zero_off_a: assert property (
    settled && sim_reg == 2'h0 && fb_reg == 16'sh0000 && !$past(ready_out)
    |-> loop_ctrl == 4'h0)
    else $error("stage driven with zero fallback");
  fallback_sp_a: assert property (
    settled && sim_reg == 2'h0 && fb_reg != 16'sh0000 && !$past(ready_out)
    && fault_pin[7:6] == 2'h0 |-> loop_ctrl.stage_on
    && loop_ctrl.pos_loop_run == intl_reg && spool_setpoint == fb_reg)
    else $error("fallback not applied as spool setpoint");
  fault_drop_a: assert property (
    $rose(|(fault_pin & 8'hEF)) && mon_reg != 2'h0 && sim_reg == 2'h0
    |-> ##[1:8] !ready_out)
    else $error("ready kept under an active fault");

  cover property (settled && sim_reg == 2'h2);
  cover property (settled && fb_reg != 16'sh0000 && !ready_out);
  cover property ($fell(ready_out) && enable_pin);
endmodule

bind ssf_supervisor ssf_monitor #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) i_mon (
  .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .enable_pin(enable_pin), .fault_pin(fault_pin),
  .param_data_bad(param_data_bad), .proc_in(proc_in),
  .loop_ctrl(loop_ctrl), .spool_setpoint(spool_setpoint),
  .current_loop_p_gain(current_loop_p_gain),
  .current_loop_i_gain(current_loop_i_gain), .pwm_step(pwm_step),
  .pwm_hz(pwm_hz), .ready_out(ready_out), .ready_led(ready_led));

// *** tb/ssf_plant_model.sv ***
`timescale 1ns/1ps

module ssf_plant_model
  import ssf_pkg::*;
#(
  parameter logic signed [15:0] DEMAND   = 16'sh0320,
  parameter logic signed [15:0] CTRL_OUT = 16'sh0190
)
(
  // clock
  input  wire logic               ref_clk,
  // stage drive
  input  wire ssf_loop_t          loop_ctrl,
  input  wire logic signed [15:0] spool_setpoint,
  // faults the bench injects
  input  wire ssf_fault_t         flt_cmd,
  // sensed side
  output ssf_fault_t              fault_pin,
  output ssf_proc_t               proc_in
);
  // the spool springs back to centre whenever the stage is off
  logic signed [15:0] pos_reg = 16'sh0000;

  always_ff @(posedge ref_clk)
    pos_reg <= loop_ctrl.stage_on ? spool_setpoint : 16'sh0000;

  // a broken solenoid wire shows as a fault level on its pin
  assign fault_pin = flt_cmd;
  assign proc_in = {DEMAND, CTRL_OUT, pos_reg,
                    loop_ctrl.stage_on ? 16'h0258 : 16'h0000, 16'h0000};
endmodule

// *** tb/test_solenoid_stage_fault_supervisor.sv ***
`timescale 1ns/1ps
`include "ssf_defs.svh"

module test_solenoid_stage_fault_supervisor
  import ssf_pkg::*;
  ;
  localparam logic signed [15:0] DEM  = 16'sh0320;
  localparam logic signed [15:0] COUT = 16'sh0190;

  logic               ref_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [7:0]         reg_addr = 8'h00;
  logic [15:0]        reg_wdata = 16'h0000;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               enable_pin = 1'b0;
  logic               param_data_bad = 1'b0;
  ssf_fault_t         flt_cmd = 8'h00;
  logic [15:0]        reg_rdata;
  ssf_fault_t         fault_pin;
  ssf_proc_t          proc_in;
  ssf_loop_t          loop_ctrl;
  logic signed [15:0] spool_setpoint;
  logic [4:0]         p_gain;
  logic [4:0]         pwm_step;
  logic [6:0]         i_gain;
  logic [11:0]        pwm_hz;
  logic               ready_out;
  logic               ready_led;
  logic               lv;
  logic [11:0]        hz_tab [20] = '{12'h03D, 12'h048, 12'h055, 12'h064,
    12'h078, 12'h096, 12'h0C8, 12'h10D, 12'h174, 12'h1E8, 12'h270, 12'h30D,
    12'h3D0, 12'h4B1, 12'h58C, 12'h61A, 12'h6C8, 12'h7A1, 12'h8B8, 12'hA2C};
  int                 n_mismatch = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  int                 tog;

  ssf_supervisor #(.FLASH_HALF_CYC(4)) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .enable_pin(enable_pin), .fault_pin(fault_pin),
    .param_data_bad(param_data_bad), .proc_in(proc_in), .loop_ctrl(loop_ctrl),
    .spool_setpoint(spool_setpoint), .current_loop_p_gain(p_gain),
    .current_loop_i_gain(i_gain), .pwm_step(pwm_step), .pwm_hz(pwm_hz),
    .ready_out(ready_out), .ready_led(ready_led));

  ssf_plant_model #(.DEMAND(DEM), .CTRL_OUT(COUT)) i_plant (
    .ref_clk(ref_clk), .loop_ctrl(loop_ctrl),
    .spool_setpoint(spool_setpoint), .flt_cmd(flt_cmd),
    .fault_pin(fault_pin), .proc_in(proc_in));

  initial
    forever #12.5 ref_clk = ~ref_clk;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 32'h0000_4E20)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    chk($sformatf("reg_%h", a), exp, reg_rdata);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  function automatic logic [15:0] ap(input logic [11:0] hz);
    return hz > 12'h3E8 ? 16'h0007 : hz < 12'h0FA ? 16'h0002 : 16'h0004;
  endfunction

  function automatic logic [15:0] ai(input logic [11:0] hz);
    return hz > 12'h3E8 ? 16'h0028 : hz < 12'h0FA ? 16'h003C : 16'h0032;
  endfunction

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    rchk(`SSF_OFS_P_GAIN, 16'h0007);
    rchk(`SSF_OFS_SPOOL, 16'h0000);
    rchk(`SSF_OFS_HIST, 16'h0000);
    rchk(8'hFC, 16'h0000);
    wr(`SSF_OFS_CTRL, 16'h0003);
    for (int s = 0; s < 20; s++)
    begin
      wr(`SSF_OFS_PWM_STEP, 16'(s));
      rchk(`SSF_OFS_PWM_HZ, {4'h0, hz_tab[s]});
      rchk(`SSF_OFS_P_GAIN, ap(hz_tab[s]));
      rchk(`SSF_OFS_I_GAIN, ai(hz_tab[s]));
      chk("pwm_hz", {4'h0, hz_tab[s]}, {4'h0, pwm_hz});
      chk("p_gain", ap(hz_tab[s]), {11'h0, p_gain});
      chk("i_gain", ai(hz_tab[s]), {9'h0, i_gain});
    end
    wr(`SSF_OFS_PWM_STEP, 16'h0014);
    rchk(`SSF_OFS_PWM_STEP, 16'h0013);
    wr(`SSF_OFS_P_GAIN, 16'h0001);
    rchk(`SSF_OFS_P_GAIN, 16'h0007);
    // manual gains, internal spool loop
    wr(`SSF_OFS_CTRL, 16'h000A);
    wr(`SSF_OFS_P_GAIN, 16'h001E);
    wr(`SSF_OFS_P_GAIN, 16'h001F);
    rchk(`SSF_OFS_P_GAIN, 16'h001E);
    wr(`SSF_OFS_I_GAIN, 16'h0064);
    wr(`SSF_OFS_I_GAIN, 16'h0065);
    wr(`SSF_OFS_I_GAIN, 16'h0000);
    rchk(`SSF_OFS_I_GAIN, 16'h0064);
    wr(`SSF_OFS_PWM_STEP, 16'h0000);
    wr(`SSF_OFS_P_GAIN, 16'h0002);
    wr(`SSF_OFS_I_GAIN, 16'h003C);
    wr(`SSF_OFS_PWM_STEP, 16'h0013);
    rchk(`SSF_OFS_P_GAIN, 16'h0002);
    wr(`SSF_OFS_P_GAIN, 16'h0007);
    wr(`SSF_OFS_I_GAIN, 16'h0028);
    @(posedge ref_clk);
    enable_pin <= 1'b1;
    tick(6);
    chk("ready", 16'h0001, {15'h0, ready_out});
    chk("loop", 16'h000E, {12'h0, loop_ctrl});
    chk("setpoint", COUT, spool_setpoint);
    rchk(`SSF_OFS_PV_DEM, DEM);
    rchk(`SSF_OFS_PV_IA, 16'h0258);
    @(posedge ref_clk);
    flt_cmd.ain6 <= 1'b1;
    tick(12);
    chk("ready", 16'h0000, {15'h0, ready_out});
    chk("loop", 16'h0000, {12'h0, loop_ctrl});
    tog = 0;
    for (int k = 0; k < 24; k++)
    begin
      lv = ready_led;
      @(negedge ref_clk);
      if (ready_led !== lv)
        tog++;
    end
    chk("led_flash", 16'h0001, {15'h0, tog > 3});
    wr(`SSF_OFS_HIST_IDX, 16'h0009);
    rchk(`SSF_OFS_HIST, 16'h0001);
    wr(`SSF_OFS_FALLBACK, 16'h01F4);
    wr(`SSF_OFS_FALLBACK, 16'h2711);
    rchk(`SSF_OFS_PV_OUT, 16'h01F4);
    chk("loop", 16'h000C, {12'h0, loop_ctrl});
    wr(`SSF_OFS_FALLBACK, 16'hD8F0);
    rchk(`SSF_OFS_FALLBACK, 16'hD8F0);
    @(posedge ref_clk);
    flt_cmd <= 8'h00;
    tick(12);
    chk("ready", 16'h0001, {15'h0, ready_out});
    // monitor off ignores the pressure input; auto with demand on trips
    wr(`SSF_OFS_CTRL, 16'h0008);
    @(posedge ref_clk);
    flt_cmd.ain31 <= 1'b1;
    tick(12);
    chk("ready", 16'h0001, {15'h0, ready_out});
    wr(`SSF_OFS_CTRL, 16'h001C);
    tick(12);
    chk("ready", 16'h0000, {15'h0, ready_out});
    @(posedge ref_clk);
    flt_cmd <= 8'h00;
    tick(12);
    wr(`SSF_OFS_SPOOL, 16'h0001);
    tick(4);
    chk("ready", 16'h0000, {15'h0, ready_out});
    chk("loop", 16'h0009, {12'h0, loop_ctrl});
    chk("setpoint", DEM, spool_setpoint);
    wr(`SSF_OFS_SPOOL, 16'h0002);
    tick(4);
    chk("loop", 16'h000E, {12'h0, loop_ctrl});
    wr(`SSF_OFS_SPOOL, 16'h0003);
    rchk(`SSF_OFS_SPOOL, 16'h0002);
    rchk(`SSF_OFS_HIST, 16'h000A);
    wr(`SSF_OFS_HIST_IDX, 16'h0008);
    rchk(`SSF_OFS_HIST, 16'h0005);
    // solenoid fault must cut the stage even with a fallback set
    wr(`SSF_OFS_SPOOL, 16'h0000);
    @(posedge ref_clk);
    flt_cmd.sol_a <= 1'b1;
    tick(12);
    chk("loop", 16'h0000, {12'h0, loop_ctrl});
    wr(`SSF_OFS_SPOOL, 16'h0002);
    @(posedge ref_clk);
    flt_cmd <= 8'h00;
    rst_b   <= 1'b0;
    param_data_bad <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    rchk(`SSF_OFS_SPOOL, 16'h0000);
    wr(`SSF_OFS_HIST_IDX, 16'h0009);
    rchk(`SSF_OFS_HIST, 16'h0000);
    rchk(`SSF_OFS_STATUS, 16'h0600);
    wr(`SSF_OFS_SAVE, 16'h0001);
    tick(4);
    chk("ready", 16'h0001, {15'h0, ready_out});
    complete_run();
  end
endmodule
